// file: logic/obd_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module obd_decoder #(
  parameter int NPER = obd_pkg::NPER
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Configuration
  input wire logic [15:0] system_config_reg,
  input wire logic [15:0] periph_enable_reg,
  input wire logic bootstrap_pin,
  input wire logic small_variant,
  input wire logic win_load,
  input wire logic [obd_pkg::ADDR_W-1:0] win_base,
  // CPU access
  input wire logic acc_req,
  input wire logic [obd_pkg::ADDR_W-1:0] acc_addr,
  input wire logic acc_byte,
  // Target selects
  output logic sel_ext,
  output logic sel_flash,
  output logic sel_tflash,
  output logic sel_low_ext_ram,
  output logic sel_high_ext_ram,
  output logic sel_rsv,
  output logic [NPER-1:0] sel_periph,
  output logic [obd_pkg::ADDR_W-1:0] tgt_addr,
  output logic acc_fault,
  // Bus characteristics
  output logic [1:0] wait_states,
  output logic tristate_wait,
  output logic bus_16bit,
  output logic [3:0] seg_lines,
  output logic [obd_pkg::ADDR_W-1:0] win_base_out
);
  ////////////////////////////////////////////////////////////////////
  // Bootstrap strap is a pin; synchronise before use
  logic boot_s;
  obd_sync u_boot (
    .clk(clk),
    .sys_rst(sys_rst),
    .din(bootstrap_pin),
    .dout(boot_s)
  );

  ////////////////////////////////////////////////////////////////////
  // High RAM window base
  logic [obd_pkg::ADDR_W-1:0] win_r;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      win_r <= obd_pkg::HIGH_EXT_RAM_AREA_RST_BASE;
    end else if (win_load) begin
      win_r <= win_base;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Decode
  logic global_periph_enable;
  logic low_ext_ram_enable;
  logic high_ext_ram_enable;
  logic first_can_enable;
  logic second_can_enable;
  logic [NPER-1:0] slot_en;
  logic [NPER*16-1:0] slot_page;
  logic [NPER-1:0] hit;
  logic [15:0] page;
  logic in_low, in_high, in_flash, in_frsv, in_tflash;
  obd_pkg::obd_tgt_type tgt;

  assign global_periph_enable = system_config_reg[obd_pkg::SYS_PERIPH_EN_BIT];
  assign low_ext_ram_enable = periph_enable_reg[obd_pkg::PE_LOW_EXT_RAM_AREA];
  assign high_ext_ram_enable = periph_enable_reg[obd_pkg::PE_HIGH_EXT_RAM_AREA];
  assign first_can_enable = periph_enable_reg[obd_pkg::PE_FIRST_CAN_CTRL];
  assign second_can_enable = periph_enable_reg[obd_pkg::PE_SECOND_CAN_CTRL];
  assign page = acc_addr[23:8];

  // Slot order: FIRST_CAN_CTRL, SECOND_CAN_CTRL, RTC, PWM, ASC, SSC, I2C, MISC
  assign slot_en = {periph_enable_reg[obd_pkg::PE_MISC],
                    periph_enable_reg[obd_pkg::PE_I2C],
                    periph_enable_reg[obd_pkg::PE_SSC],
                    periph_enable_reg[obd_pkg::PE_ASC],
                    periph_enable_reg[obd_pkg::PE_PWM],
                    periph_enable_reg[obd_pkg::PE_RTC],
                    second_can_enable,
                    first_can_enable};
  assign slot_page = {obd_pkg::PG_MISC, obd_pkg::PG_I2C, obd_pkg::PG_SSC,
                      obd_pkg::PG_ASC, obd_pkg::PG_PWM, obd_pkg::PG_RTC,
                      obd_pkg::PG_SECOND_CAN_CTRL, obd_pkg::PG_FIRST_CAN_CTRL};

  obd_periph_match #(
    .NPER(NPER)
  ) u_match (
    .page(page),
    .global_periph_enable(global_periph_enable),
    .slot_en(slot_en),
    .slot_page(slot_page),
    .hit(hit)
  );

  assign in_low = (acc_addr >= obd_pkg::LOW_EXT_RAM_AREA_LO) && (acc_addr <= obd_pkg::LOW_EXT_RAM_AREA_HI);
  // Only address bits above the 16 KB granule are decoded, so a smaller RAM
  // mirrors within it; the small part still answers over the whole granule
  assign in_high = (acc_addr[23:obd_pkg::HIGH_EXT_RAM_AREA_DEC_BITS] ==
                    win_r[23:obd_pkg::HIGH_EXT_RAM_AREA_DEC_BITS]);
  // Upper half of segment 0 stays free, else RAM and peripherals would be shadowed
  assign in_flash = (acc_addr <= obd_pkg::FLASH_SEG0_HI) ||
                    ((acc_addr >= obd_pkg::FLASH_UP_LO) &&
                     (acc_addr <= obd_pkg::FLASH_HI));
  assign in_frsv = (acc_addr >= obd_pkg::FLASH_RSV_LO) &&
                   (acc_addr <= obd_pkg::FLASH_RSV_HI);
  assign in_tflash = boot_s && (acc_addr <= obd_pkg::TFLASH_HI);

  // Priority: enabled internal region first, else external
  always_comb begin
    if (in_tflash) begin
      tgt = obd_pkg::TGT_TFLASH;
    end else if (in_flash) begin
      tgt = obd_pkg::TGT_FLASH;
    end else if (in_frsv) begin
      tgt = obd_pkg::TGT_RSV;
    end else if (in_low && global_periph_enable && low_ext_ram_enable) begin
      tgt = obd_pkg::TGT_LOW_EXT_RAM_AREA;
    end else if (in_high && global_periph_enable && high_ext_ram_enable) begin
      tgt = obd_pkg::TGT_HIGH_EXT_RAM_AREA;
    end else if (|hit) begin
      tgt = obd_pkg::TGT_PERIPH;
    end else begin
      tgt = obd_pkg::TGT_EXT;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Registered selects; one and only one is high per taken access
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sel_ext <= 1'b0;
      sel_flash <= 1'b0;
      sel_tflash <= 1'b0;
      sel_low_ext_ram <= 1'b0;
      sel_high_ext_ram <= 1'b0;
      sel_rsv <= 1'b0;
      sel_periph <= '0;
      tgt_addr <= '0;
    end else begin
      sel_ext <= acc_req && (tgt == obd_pkg::TGT_EXT);
      sel_flash <= acc_req && (tgt == obd_pkg::TGT_FLASH);
      sel_tflash <= acc_req && (tgt == obd_pkg::TGT_TFLASH);
      sel_low_ext_ram <= acc_req && (tgt == obd_pkg::TGT_LOW_EXT_RAM_AREA);
      sel_high_ext_ram <= acc_req && (tgt == obd_pkg::TGT_HIGH_EXT_RAM_AREA);
      sel_rsv <= acc_req && (tgt == obd_pkg::TGT_RSV);
      sel_periph <= (acc_req && (tgt == obd_pkg::TGT_PERIPH)) ? hit : '0;
      tgt_addr <= acc_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Bus characteristics per region
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wait_states <= obd_pkg::WAIT_XRAM;
      tristate_wait <= 1'b0;
      bus_16bit <= 1'b0;
      acc_fault <= 1'b0;
    end else begin
      tristate_wait <= 1'b0;
      if (acc_req && (tgt == obd_pkg::TGT_PERIPH)) begin
        wait_states <= obd_pkg::WAIT_PERIPH;
        bus_16bit <= 1'b1;
        acc_fault <= acc_byte;
      end else if (acc_req && ((tgt == obd_pkg::TGT_LOW_EXT_RAM_AREA) ||
                               (tgt == obd_pkg::TGT_HIGH_EXT_RAM_AREA))) begin
        wait_states <= obd_pkg::WAIT_XRAM;
        bus_16bit <= 1'b1;
        acc_fault <= 1'b0;
      end else begin
        // External, flash and reserved accesses get fixed WAIT_XRAM timing with bus_16bit low
        wait_states <= obd_pkg::WAIT_XRAM;
        bus_16bit <= 1'b0;
        acc_fault <= 1'b0;
      end
    end
  end

  // CAN use limits the segment address lines on port 4
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      seg_lines <= obd_pkg::SEG_LINES_FULL;
      win_base_out <= obd_pkg::HIGH_EXT_RAM_AREA_RST_BASE;
    end else begin
      seg_lines <= (global_periph_enable && (first_can_enable || second_can_enable))
                   ? obd_pkg::SEG_LINES_CAN : obd_pkg::SEG_LINES_FULL;
      win_base_out <= win_r;
    end
  end

  // The variant input only matters to RAM sizing outside this decoder
  logic unused_ok;
  assign unused_ok = small_variant;
endmodule
`default_nettype wire

// file: logic/obd_periph_match.sv
`timescale 1ns/1ps
`default_nettype none
module obd_periph_match #(
  parameter int NPER = 8
) (
  // Access page
  input wire logic [15:0] page,
  // Enables
  input wire logic global_periph_enable,
  input wire logic [NPER-1:0] slot_en,
  input wire logic [NPER*16-1:0] slot_page,
  // Hits
  output logic [NPER-1:0] hit
);
  genvar g;
  generate
    for (g = 0; g < NPER; g++) begin : g_slot
      assign hit[g] = global_periph_enable && slot_en[g] &&
                      (page == slot_page[g*16 +: 16]);
    end
  endgenerate
endmodule
`default_nettype wire

// file: logic/obd_pkg.sv
package obd_pkg;
  // Address space
  localparam int ADDR_W = 24;
  localparam logic [23:0] FLASH_LO = 24'h00_0000;
  localparam logic [23:0] FLASH_HI = 24'h02_FFFF;
  // Blocks 0..3 fill the lower half of segment 0, block 4 starts in segment 1
  localparam logic [23:0] FLASH_SEG0_HI = 24'h00_7FFF;
  localparam logic [23:0] FLASH_UP_LO = 24'h01_8000;
  localparam logic [23:0] FLASH_RSV_LO = 24'h03_0000;
  localparam logic [23:0] FLASH_RSV_HI = 24'h04_FFFF;
  localparam logic [23:0] TFLASH_LO = 24'h00_0000;
  localparam logic [23:0] TFLASH_HI = 24'h00_1FFF;
  localparam logic [23:0] LOW_EXT_RAM_AREA_LO = 24'h00_E000;
  localparam logic [23:0] LOW_EXT_RAM_AREA_HI = 24'h00_E7FF;
  localparam logic [23:0] HIGH_EXT_RAM_AREA_RST_BASE = 24'h09_0000;
  // High RAM decode: size of the mirror granule (16 KB)
  localparam int HIGH_EXT_RAM_AREA_DEC_BITS = 14;
  // Peripheral pages, 256 bytes each, selected by address bits 23:8
  localparam logic [15:0] PG_FIRST_CAN_CTRL = 16'h00EF;
  localparam logic [15:0] PG_SECOND_CAN_CTRL = 16'h00EE;
  localparam logic [15:0] PG_RTC = 16'h00ED;
  localparam logic [15:0] PG_PWM = 16'h00EC;
  localparam logic [15:0] PG_ASC = 16'h00E9;
  localparam logic [15:0] PG_SSC = 16'h00E8;
  localparam logic [15:0] PG_I2C = 16'h00EA;
  localparam logic [15:0] PG_MISC = 16'h00EB;
  // Enable bit positions
  localparam int SYS_PERIPH_EN_BIT = 2;
  localparam int PE_FIRST_CAN_CTRL = 0;
  localparam int PE_SECOND_CAN_CTRL = 1;
  localparam int PE_LOW_EXT_RAM_AREA = 2;
  localparam int PE_HIGH_EXT_RAM_AREA = 3;
  localparam int PE_RTC = 4;
  localparam int PE_PWM = 6;
  localparam int PE_ASC = 7;
  localparam int PE_SSC = 8;
  localparam int PE_I2C = 9;
  localparam int PE_MISC = 10;
  // Access timing, in CPU cycles, and segment address line counts
  localparam logic [1:0] WAIT_XRAM = 2'h0;
  localparam logic [1:0] WAIT_PERIPH = 2'h2;
  localparam logic [3:0] SEG_LINES_FULL = 4'h8;
  localparam logic [3:0] SEG_LINES_CAN = 4'h4;
  // Number of peripheral slots
  localparam int NPER = 8;
  // One-hot targets
  typedef enum logic [11:0] {
    TGT_EXT = 12'h001,
    TGT_FLASH = 12'h002,
    TGT_TFLASH = 12'h004,
    TGT_LOW_EXT_RAM_AREA = 12'h008,
    TGT_HIGH_EXT_RAM_AREA = 12'h010,
    TGT_PERIPH = 12'h020,
    TGT_RSV = 12'h040
  } obd_tgt_type;
endpackage

// file: logic/obd_sync.sv
`timescale 1ns/1ps
`default_nettype none
module obd_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Level
  input wire logic din,
  output logic dout
);
  logic s1_r;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_r <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_r <= din;
      dout <= s1_r;
    end
  end
endmodule
`default_nettype wire

// file: tb/obd_checker.sv
`timescale 1ns/1ps
`default_nettype none
module obd_checker #(
  parameter int NPER = 8
) (
  // Clock, reset, inputs
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [15:0] system_config_reg,
  input wire logic [15:0] periph_enable_reg,
  input wire logic bootstrap_pin,
  input wire logic win_load,
  input wire logic [23:0] win_base,
  input wire logic acc_req,
  input wire logic [23:0] acc_addr,
  // Outputs
  input wire logic sel_ext,
  input wire logic sel_flash,
  input wire logic sel_tflash,
  input wire logic sel_low_ext_ram,
  input wire logic sel_high_ext_ram,
  input wire logic sel_rsv,
  input wire logic [NPER-1:0] sel_periph,
  input wire logic [1:0] wait_states,
  input wire logic tristate_wait,
  input wire logic bus_16bit,
  input wire logic [3:0] seg_lines,
  input wire logic [23:0] win_base_out
);
  logic g;
  logic low_rng;
  logic flash_rng;
  logic [NPER+5:0] all_sel;
  assign g = system_config_reg[2];
  assign low_rng = acc_addr >= 24'h00_E000 && acc_addr <= 24'h00_E7FF;
  assign flash_rng = acc_addr <= 24'h00_7FFF || (acc_addr >= 24'h01_8000 && acc_addr <= 24'h02_FFFF);
  assign all_sel = {sel_ext, sel_flash, sel_tflash, sel_low_ext_ram, sel_high_ext_ram, sel_rsv,
    sel_periph};
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Pin must be steady past both sync stages before the map can follow it
  sequence s_boot; bootstrap_pin [*3]; endsequence
  sequence s_user; !bootstrap_pin [*3]; endsequence
  ////////////////////////////////////////////////////////////////////////////////
  AST_ONE_SEL: assert property (acc_req |=> $onehot(all_sel))
    else $error("select count not one");
  AST_IDLE: assert property (!acc_req |=> all_sel == '0)
    else $error("select without request");
  AST_TFLASH: assert property (s_boot ##0 (acc_req && acc_addr <= 24'h00_1FFF) |=> sel_tflash)
    else $error("test flash not mapped");
  AST_FLASH: assert property (s_user ##0 (acc_req && flash_rng) |=> sel_flash)
    else $error("user flash not mapped");
  AST_RSV: assert property (acc_req && acc_addr[23:16] inside {8'h03, 8'h04} |=> sel_rsv)
    else $error("reserved flash not flagged");
  AST_LOW_ON: assert property (acc_req && low_rng && g && periph_enable_reg[2] |=> sel_low_ext_ram)
    else $error("low ram not selected");
  AST_LOW_OFF: assert property (acc_req && low_rng && !(g && periph_enable_reg[2]) |=> sel_ext)
    else $error("low ram not sent outside");
  AST_FIRST_CAN_CTRL: assert property (acc_req && acc_addr[23:8] == 16'h00EF && g && periph_enable_reg[0]
    |=> sel_periph[0])
    else $error("first can not selected");
  AST_XRAM_T: assert property (sel_low_ext_ram || sel_high_ext_ram |-> wait_states == 2'h0 && bus_16bit)
    else $error("ram timing wrong");
  AST_PER_T: assert property (|sel_periph |-> wait_states == 2'h2 && !tristate_wait && bus_16bit)
    else $error("peripheral timing wrong");
  AST_SEG: assert property (g && |periph_enable_reg[1:0] |=> seg_lines == 4'h4)
    else $error("segment lines not limited");
  AST_WIN: assert property (win_load |-> ##2 win_base_out == $past(win_base, 2))
    else $error("window not loaded");
endmodule
bind obd_decoder obd_checker #(.NPER(NPER)) u_obd_checker (.clk(clk), .sys_rst(sys_rst),
  .system_config_reg(system_config_reg), .periph_enable_reg(periph_enable_reg),
  .bootstrap_pin(bootstrap_pin), .win_load(win_load), .win_base(win_base), .acc_req(acc_req),
  .acc_addr(acc_addr), .sel_ext(sel_ext), .sel_flash(sel_flash), .sel_tflash(sel_tflash),
  .sel_low_ext_ram(sel_low_ext_ram), .sel_high_ext_ram(sel_high_ext_ram), .sel_rsv(sel_rsv),
  .sel_periph(sel_periph), .wait_states(wait_states), .tristate_wait(tristate_wait),
  .bus_16bit(bus_16bit), .seg_lines(seg_lines), .win_base_out(win_base_out));
`default_nettype wire

// file: tb/obd_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module obd_cpu_model (
  // Clock
  input wire logic clk,
  // Access
  output logic acc_req,
  output logic [23:0] acc_addr,
  output logic acc_byte
);
  initial begin
    acc_req = 1'b0;
    acc_addr = 24'h00_0000;
    acc_byte = 1'b0;
  end
  // Held through the taking edge, then dropped; a stale address would hide decode slips
  task automatic access(input logic [23:0] a, input logic b);
    @(posedge clk);
    acc_req <= 1'b1;
    acc_addr <= a;
    acc_byte <= b;
    @(posedge clk);
    acc_req <= 1'b0;
    acc_addr <= ~a;
    #1;
  endtask
endmodule
`default_nettype wire

// file: tb/obd_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
module obd_decoder_tb;
  logic clk = 1'b0, sys_rst = 1'b1, bootstrap_pin = 1'b0, small_variant = 1'b1, win_load = 1'b0;
  logic [15:0] system_config_reg = 16'h0000, periph_enable_reg = 16'h0000;
  logic [23:0] win_base = 24'h00_0000, win_exp = 24'h09_0000, tgt_addr, win_base_out;
  logic acc_req, acc_byte, sel_ext, sel_flash, sel_tflash, sel_low_ext_ram, sel_high_ext_ram;
  logic sel_rsv, acc_fault, tristate_wait, bus_16bit;
  logic [23:0] acc_addr;
  logic [7:0] sel_periph;
  logic [1:0] wait_states;
  logic [3:0] seg_lines;
  logic [7:0] pg [8] = '{8'hEF, 8'hEE, 8'hED, 8'hEC, 8'hE9, 8'hE8, 8'hEA, 8'hEB};
  int pb [8] = '{0, 1, 4, 6, 7, 8, 9, 10};
  int bad_count = 0, checks_done = 0;
  always #4 clk = ~clk;
  obd_decoder u_obd_decoder (.clk(clk), .sys_rst(sys_rst), .system_config_reg(system_config_reg),
    .periph_enable_reg(periph_enable_reg), .bootstrap_pin(bootstrap_pin),
    .small_variant(small_variant), .win_load(win_load), .win_base(win_base), .acc_req(acc_req),
    .acc_addr(acc_addr), .acc_byte(acc_byte), .sel_ext(sel_ext), .sel_flash(sel_flash),
    .sel_tflash(sel_tflash), .sel_low_ext_ram(sel_low_ext_ram),
    .sel_high_ext_ram(sel_high_ext_ram), .sel_rsv(sel_rsv), .sel_periph(sel_periph),
    .tgt_addr(tgt_addr), .acc_fault(acc_fault), .wait_states(wait_states),
    .tristate_wait(tristate_wait), .bus_16bit(bus_16bit), .seg_lines(seg_lines),
    .win_base_out(win_base_out));
  obd_cpu_model u_obd_cpu_model (.clk(clk), .acc_req(acc_req), .acc_addr(acc_addr),
    .acc_byte(acc_byte));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [13:0] exp_sel(input logic [23:0] a);
    logic g;
    g = system_config_reg[2];
    if (bootstrap_pin && a <= 24'h00_1FFF) return 14'h0800;
    if (a <= 24'h00_7FFF || (a >= 24'h01_8000 && a <= 24'h02_FFFF)) return 14'h1000;
    if (a >= 24'h03_0000 && a <= 24'h04_FFFF) return 14'h0100;
    if (a >= 24'h00_E000 && a <= 24'h00_E7FF && g && periph_enable_reg[2]) return 14'h0400;
    if (a[23:14] == win_exp[23:14] && g && periph_enable_reg[3]) return 14'h0200;
    for (int k = 0; k < 8; k++)
      if (a[23:8] == {8'h00, pg[k]} && g && periph_enable_reg[pb[k]]) return 14'h0001 << k;
    return 14'h2000;
  endfunction
  task automatic try(input logic [23:0] a, input logic b);
    logic [13:0] e;
    // Expectation taken once the configuration written just before has settled
    u_obd_cpu_model.access(a, b);
    e = exp_sel(a);
    chk({sel_ext, sel_flash, sel_tflash, sel_low_ext_ram, sel_high_ext_ram, sel_rsv, sel_periph}, e);
    chk(tgt_addr, a);
    chk({acc_fault, wait_states, tristate_wait, bus_16bit},
      |e[7:0] ? {b, 4'b1001} : (|e[10:9] ? 5'b00001 : 5'b00000));
  endtask
  task automatic setc(input logic g, input logic [15:0] p);
    @(posedge clk);
    system_config_reg <= g ? 16'h0004 : 16'h0000;
    periph_enable_reg <= p;
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_flash();
    try(24'h00_0000, 1'b1);
    try(24'h00_7FFF, 1'b0);
    try(24'h00_8000, 1'b0);
    try(24'h01_8000, 1'b1);
    try(24'h02_FFFF, 1'b0);
    try(24'h03_0000, 1'b1);
    try(24'h04_FFFF, 1'b0);
    try(24'h05_0000, 1'b0);
    @(posedge clk);
    bootstrap_pin <= 1'b1;
    repeat (4) @(posedge clk);
    try(24'h00_0000, 1'b0);
    try(24'h00_1FFF, 1'b1);
    try(24'h00_2000, 1'b0);
    @(posedge clk);
    bootstrap_pin <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic t_ram();
    for (int c = 0; c < 4; c++) begin
      setc(c[0], {14'h0, c[1], 1'b0} << 1);
      try(24'h00_E000, 1'b1);
      try(24'h00_E7FF, 1'b0);
    end
    setc(1'b1, 16'h0008);
    try(24'h09_0000, 1'b1);
    try(24'h09_3FFE, 1'b0);
    @(posedge clk);
    win_load <= 1'b1;
    win_base <= 24'h0A_0000;
    @(posedge clk);
    win_load <= 1'b0;
    win_exp = 24'h0A_0000;
    // The window output trails the load by one more register stage
    @(posedge clk);
    #1 chk(win_base_out, 24'h0A_0000);
    try(24'h0A_1000, 1'b0);
    try(24'h09_0000, 1'b0);
    setc(1'b0, 16'h0008);
    try(24'h0A_0000, 1'b0);
  endtask
  task automatic t_periph();
    foreach (pg[k]) begin
      setc(1'b1, 16'h0001 << pb[k]);
      try({8'h00, pg[k], 8'h00}, 1'b0);
      try({8'h00, pg[k], 8'hFE}, 1'b1);
      chk(seg_lines, k < 2 ? 4'h4 : 4'h8);
      setc(1'b0, 16'h0001 << pb[k]);
      try({8'h00, pg[k], 8'h10}, 1'b0);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1 chk({win_base_out, seg_lines}, {24'h09_0000, 4'h8});
    t_flash();
    t_ram();
    t_periph();
    give_verdict();
  end
  initial begin
    #200000;
    bad_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
